// ==== vdc_dev.sv ====
// Disk controller end: host registers, event block fetch, DMA and write-back
`timescale 1ns/100ps
module vdc_dev #(
   parameter int TENURE_CYCLES = vdc_pkg::TENURE_CYC
) (
   input  wire logic        core_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        ce_i,
   vdc_if.dev               bus,
   input  wire logic [3:0]  drive_ready_i,
   input  wire logic [15:0] dsk_rx_data_i,
   input  wire logic        dsk_rx_valid_i,
   output logic             dsk_rx_ready_o,
   output logic [15:0]      dsk_tx_data_o,
   output logic             dsk_tx_valid_o,
   input  wire logic        dsk_tx_ready_i,
   output logic [1:0]       drive_sel_o,
   output logic [3:0]       head_o,
   output logic [9:0]       cyl_o
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00, ST_FETCH = 2'b01, ST_XFER = 2'b10, ST_WBACK = 2'b11
   } vdc_state_t;

   vdc_state_t  st_r;
   logic [7:0]  ctrl_r, vector_r, src_r, rdata_r;
   logic [23:0] ptr_r, buf_r;
   logic        rack_r, start_r, done_r, err_r, breq_r, mreq_r, mwe_r;
   logic [23:0] maddr_r;
   logic [15:0] mwdata_r, cmdw_r, cyl_r, cnt_r, data_r, tx_r;
   logic [2:0]  idx_r;
   logic        have_r, txv_r;
   logic [31:0] chk_r;
   logic [15:0] ten_r;
   logic [1:0]  drv_r;
   logic        take, own, expired, to_mem, from_mem, verify, rx_fire, bad_cmd, bad_drv;
   logic [3:0]  op;

   // Bit-serial check over one word, MSB first
   function automatic logic [31:0] vdc_chk(input logic [31:0] s, input logic [15:0] w,
                                           input logic ecc);
      logic [31:0] c;
      logic        fb;
      c = s;
      for (int i = 15; i >= 0; i--) begin
         if (ecc) begin
            fb = c[31] ^ w[i];
            c  = {c[30:0], 1'b0} ^ (fb ? vdc_pkg::POLY32 : 32'h00000000);
         end else begin
            fb = c[15] ^ w[i];
            c  = {16'h0000, c[14:0], 1'b0} ^ (fb ? {16'h0000, vdc_pkg::POLY16} : 32'h00000000);
         end
      end
      return c;
   endfunction

   // Is the drive a floppy in the current configuration
   function automatic logic vdc_is_fd(input logic [1:0] d, input logic all_fd);
      return all_fd | d[1];
   endfunction

   assign take = bus.rsel & ~rack_r;
   assign own = breq_r & bus.bgnt;
   assign expired = ten_r >= 16'(TENURE_CYCLES - 1);
   assign op = cmdw_r[vdc_pkg::CMDW_OP +: 4];
   assign to_mem = op == vdc_pkg::CMD_RD_MULTI || op == vdc_pkg::CMD_TRANSP
                   || op == vdc_pkg::CMD_RD_ID;
   assign from_mem = op == vdc_pkg::CMD_WR_MULTI || op == vdc_pkg::CMD_WR_DEL
                     || op == vdc_pkg::CMD_FORMAT;
   assign verify = op == vdc_pkg::CMD_VERIFY;
   assign dsk_rx_ready_o = st_r == ST_XFER && (to_mem || verify) && !have_r && cnt_r != 16'h0000;
   assign rx_fire = dsk_rx_ready_o & dsk_rx_valid_i;
   assign dsk_tx_valid_o = txv_r;
   assign dsk_tx_data_o = tx_r;
   // Errors judged on fetched fields; used at end of fetch and in the write-back status word
   assign bad_cmd = op > vdc_pkg::CMD_CORRECT;
   assign bad_drv = !drive_ready_i[drv_r] || cyl_r[15:10] != 6'h00
                    || (vdc_is_fd(drv_r, ctrl_r[vdc_pkg::CTRL_ALL_FD])
                        && {6'h00, cmdw_r[vdc_pkg::CMDW_HEAD +: 4]} > vdc_pkg::FD_MAX_HEAD);

   assign bus.rack = rack_r;
   assign bus.rrdata = rdata_r;
   assign bus.irq = |src_r;
   assign bus.vector = vector_r;
   assign bus.breq = breq_r;
   assign bus.mreq = mreq_r;
   assign bus.mwe = mwe_r;
   assign bus.maddr = maddr_r;
   assign bus.mwdata = mwdata_r;

   // Host register port, one cycle to answer
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         rack_r <= 1'b0;
         rdata_r <= 8'h00;
         ctrl_r <= vdc_pkg::CTRL_RST;
         vector_r <= vdc_pkg::VEC_RST;
         ptr_r <= 24'h000000;
         start_r <= 1'b0;
      end else if (ce_i) begin
         rack_r <= take;
         start_r <= 1'b0;
         if (take && bus.rwe) begin
            unique case (bus.raddr)
               vdc_pkg::REG_CTRL: begin
                  ctrl_r <= {1'b0, bus.rwdata[6:1], 1'b0};
                  start_r <= bus.rwdata[vdc_pkg::CTRL_GO] && st_r == ST_IDLE;
               end
               vdc_pkg::REG_VECTOR: vector_r <= bus.rwdata;
               vdc_pkg::REG_PTR_LO: ptr_r[7:0] <= bus.rwdata;
               vdc_pkg::REG_PTR_MID: ptr_r[15:8] <= bus.rwdata;
               vdc_pkg::REG_PTR_HI: ptr_r[23:16] <= bus.rwdata;
               default: ;
            endcase
         end
         if (take) begin
            unique case (bus.raddr)
               vdc_pkg::REG_CTRL: rdata_r <= {st_r != ST_IDLE, ctrl_r[6:0]};
               vdc_pkg::REG_VECTOR: rdata_r <= vector_r;
               vdc_pkg::REG_PTR_LO: rdata_r <= ptr_r[7:0];
               vdc_pkg::REG_PTR_MID: rdata_r <= ptr_r[15:8];
               vdc_pkg::REG_PTR_HI: rdata_r <= ptr_r[23:16];
               vdc_pkg::REG_IRQ_SRC: rdata_r <= src_r;
               vdc_pkg::REG_DRV_STAT: rdata_r <= {2'b00, ctrl_r[vdc_pkg::CTRL_ALL_FD],
                                                   st_r != ST_IDLE, drive_ready_i};
               default: rdata_r <= 8'h00;
            endcase
         end
      end
   end

   // Interrupt sources: read or init clears, a new completion wins
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         src_r <= 8'h00;
      end else if (ce_i) begin
         if ((take && !bus.rwe && bus.raddr == vdc_pkg::REG_IRQ_SRC)
             || (take && bus.rwe && bus.raddr == vdc_pkg::REG_CTRL
                 && bus.rwdata[vdc_pkg::CTRL_INIT])) begin
            src_r <= 8'h00;
         end
         if (done_r) begin
            src_r[vdc_pkg::SRC_DONE] <= 1'b1;
            src_r[vdc_pkg::SRC_ERR] <= err_r;
         end
      end
   end

   // Tenure timer, runs only while the bus is ours; holds while the clock enable is low
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i || (ce_i && !own)) begin
         ten_r <= 16'h0000;
      end else if (ce_i && !expired) begin
         ten_r <= ten_r + 16'h0001;
      end
   end

   // Disk transmit side drains the word fetched from memory
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         txv_r <= 1'b0;
         tx_r <= 16'h0000;
      end else if (ce_i) begin
         if (txv_r && dsk_tx_ready_i) begin
            txv_r <= 1'b0;
         end
         if (st_r == ST_XFER && from_mem && bus.mack) begin
            txv_r <= 1'b1;
            tx_r <= bus.mrdata;
         end
      end
   end

   // Command sequencer and bus master
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         st_r <= ST_IDLE;
         breq_r <= 1'b0;
         mreq_r <= 1'b0;
         mwe_r <= 1'b0;
         maddr_r <= 24'h000000;
         mwdata_r <= 16'h0000;
         idx_r <= 3'h0;
         cmdw_r <= 16'h0000;
         cyl_r <= 16'h0000;
         buf_r <= 24'h000000;
         cnt_r <= 16'h0000;
         data_r <= 16'h0000;
         have_r <= 1'b0;
         chk_r <= vdc_pkg::SEED;
         drv_r <= 2'b00;
         done_r <= 1'b0;
         err_r <= 1'b0;
         drive_sel_o <= 2'b00;
         head_o <= 4'h0;
         cyl_o <= 10'h000;
      end else if (ce_i) begin
         done_r <= 1'b0;
         if (bus.mack) begin
            mreq_r <= 1'b0;
         end
         unique case (st_r)
            ST_IDLE: begin
               if (start_r) begin
                  drv_r <= ctrl_r[vdc_pkg::CTRL_DRV +: 2];
                  idx_r <= vdc_pkg::ECB_CMD;
                  chk_r <= vdc_pkg::SEED;
                  breq_r <= 1'b1;
                  st_r <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               if (own && !mreq_r) begin
                  mreq_r <= 1'b1;
                  mwe_r <= 1'b0;
                  maddr_r <= ptr_r + {20'h00000, idx_r, 1'b0};
               end
               if (bus.mack) begin
                  idx_r <= idx_r + 3'h1;
                  unique case (idx_r)
                     vdc_pkg::ECB_CMD: cmdw_r <= bus.mrdata;
                     vdc_pkg::ECB_CYL: cyl_r <= bus.mrdata;
                     vdc_pkg::ECB_BUF_HI: buf_r[23:16] <= bus.mrdata[7:0];
                     vdc_pkg::ECB_BUF_LO: buf_r[15:0] <= bus.mrdata;
                     default: begin
                        cnt_r <= bus.mrdata;
                        breq_r <= 1'b0;
                        err_r <= bad_cmd || bad_drv;
                        if (bad_cmd || bad_drv) begin
                           st_r <= ST_WBACK;
                        end else begin
                           drive_sel_o <= drv_r;
                           head_o <= op == vdc_pkg::CMD_RECAL ? 4'h0 : cmdw_r[11:8];
                           cyl_o <= op == vdc_pkg::CMD_RECAL ? 10'h000 : cyl_r[9:0];
                           st_r <= (to_mem || from_mem || verify) ? ST_XFER : ST_WBACK;
                        end
                     end
                  endcase
               end
            end
            ST_XFER: begin
               if (rx_fire) begin
                  chk_r <= vdc_chk(chk_r, dsk_rx_data_i, cmdw_r[vdc_pkg::CMDW_ECC]);
                  if (verify) begin
                     cnt_r <= cnt_r - 16'h0001;
                  end else begin
                     data_r <= dsk_rx_data_i;
                     have_r <= 1'b1;
                  end
               end
               if (!breq_r && !own && (have_r || (from_mem && !txv_r && cnt_r != 16'h0000))) begin
                  breq_r <= 1'b1;
               end
               if (own && !mreq_r && !expired && (have_r || (from_mem && !txv_r
                   && cnt_r != 16'h0000))) begin
                  mreq_r <= 1'b1;
                  mwe_r <= have_r;
                  maddr_r <= buf_r;
                  mwdata_r <= data_r;
               end
               if (bus.mack) begin
                  buf_r <= buf_r + 24'h000002;
                  cnt_r <= cnt_r - 16'h0001;
                  have_r <= 1'b0;
                  if (from_mem) begin
                     chk_r <= vdc_chk(chk_r, bus.mrdata, cmdw_r[vdc_pkg::CMDW_ECC]);
                  end
                  if (!cmdw_r[vdc_pkg::CMDW_MODE]) begin
                     breq_r <= 1'b0;
                  end
               end
               if (own && !mreq_r && expired) begin
                  breq_r <= 1'b0;
               end
               if (cnt_r == 16'h0000 && !have_r && !txv_r && !mreq_r) begin
                  breq_r <= 1'b0;
                  idx_r <= vdc_pkg::ECB_STATUS;
                  st_r <= ST_WBACK;
               end
            end
            ST_WBACK: begin
               if (!breq_r && !own && !mreq_r && !bus.mack) begin
                  breq_r <= 1'b1;
                  idx_r <= vdc_pkg::ECB_STATUS;
               end
               if (own && !mreq_r && !bus.mack) begin
                  mreq_r <= 1'b1;
                  mwe_r <= 1'b1;
                  maddr_r <= ptr_r + {20'h00000, idx_r, 1'b0};
                  unique case (idx_r)
                     vdc_pkg::ECB_STATUS: mwdata_r <= {13'h0000, err_r && bad_drv,
                                                       err_r && bad_cmd, 1'b1};
                     vdc_pkg::ECB_RESID: mwdata_r <= cnt_r;
                     default: mwdata_r <= chk_r[15:0];
                  endcase
               end
               if (bus.mack) begin
                  idx_r <= idx_r + 3'h1;
                  if (idx_r == vdc_pkg::ECB_CHECK) begin
                     breq_r <= 1'b0;
                     done_r <= 1'b1;
                     st_r <= ST_IDLE;
                  end
               end
            end
         endcase
      end
   end
endmodule

// ==== vdc_pkg.sv ====
// Shared constants and types of the disk controller host/device link
package vdc_pkg;
   // Timing
   localparam int CLK_MHZ    = 100;
   localparam int TENURE_US  = 200;
   localparam int TENURE_CYC = TENURE_US * CLK_MHZ;
   // Device register indices (byte wide, seven of them)
   localparam logic [2:0] REG_CTRL     = 3'h0;
   localparam logic [2:0] REG_VECTOR   = 3'h1;
   localparam logic [2:0] REG_PTR_LO   = 3'h2;
   localparam logic [2:0] REG_PTR_MID  = 3'h3;
   localparam logic [2:0] REG_PTR_HI   = 3'h4;
   localparam logic [2:0] REG_IRQ_SRC  = 3'h5;
   localparam logic [2:0] REG_DRV_STAT = 3'h6;
   localparam logic [2:0] REG_LAST     = 3'h6;
   // Control register fields
   localparam int CTRL_GO     = 0;
   localparam int CTRL_INIT   = 1;
   localparam int CTRL_ALL_FD = 2;
   localparam int CTRL_DRV    = 4;
   localparam int CTRL_BUSY   = 7;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] VEC_RST  = 8'h0F;
   // Interrupt source bits
   localparam int SRC_DONE = 0;
   localparam int SRC_ERR  = 1;
   // Command event block word indices; words 5..7 are dynamic
   localparam logic [2:0] ECB_CMD    = 3'h0;
   localparam logic [2:0] ECB_CYL    = 3'h1;
   localparam logic [2:0] ECB_BUF_HI = 3'h2;
   localparam logic [2:0] ECB_BUF_LO = 3'h3;
   localparam logic [2:0] ECB_COUNT  = 3'h4;
   localparam logic [2:0] ECB_STATUS = 3'h5;
   localparam logic [2:0] ECB_RESID  = 3'h6;
   localparam logic [2:0] ECB_CHECK  = 3'h7;
   // Command word fields
   localparam int CMDW_OP   = 0;
   localparam int CMDW_MODE = 4;
   localparam int CMDW_ECC  = 5;
   localparam int CMDW_HEAD = 8;
   // Status word bits
   localparam int STW_DONE = 0;
   localparam int STW_BAD_CMD = 1;
   localparam int STW_BAD_DRV = 2;
   localparam logic [15:0] POLY16 = 16'h1021;
   localparam logic [31:0] POLY32 = 32'h04C11DB7;
   localparam logic [31:0] SEED   = 32'hFFFFFFFF;
   localparam logic [9:0] FD_MAX_HEAD = 10'h001;
   typedef enum logic [3:0] {
      CMD_RECAL    = 4'h0, CMD_RD_ID    = 4'h1, CMD_RD_MULTI = 4'h2,
      CMD_WR_MULTI = 4'h3, CMD_FORMAT   = 4'h4, CMD_WR_DEL   = 4'h5,
      CMD_VERIFY   = 4'h6, CMD_TRANSP   = 4'h7, CMD_CORRECT  = 4'h8
   } vdc_cmd_t;
   // Host adapter APB map
   localparam logic [11:0] H_IRQ_STAT = 12'h000;
   localparam logic [11:0] H_IRQ_CLR  = 12'h004;
   localparam logic [11:0] H_IRQ_EN   = 12'h008;
   localparam logic [11:0] H_DEVREG   = 12'h100;
   localparam logic [11:0] H_MEM      = 12'h800;
   localparam int MEM_WORDS = 256;
   localparam int HI_DEV_IRQ = 0;
   localparam int HI_BUS_REL = 1;
endpackage

// ==== vdc_if.sv ====
// Link between the controller and its host: register port and memory bus
`timescale 1ns/100ps
interface vdc_if;
   logic        rsel;
   logic        rwe;
   logic [2:0]  raddr;
   logic [7:0]  rwdata;
   logic [7:0]  rrdata;
   logic        rack;
   logic        irq;
   logic [7:0]  vector;
   logic        breq;
   logic        bgnt;
   logic        mreq;
   logic        mwe;
   logic [23:0] maddr;
   logic [15:0] mwdata;
   logic [15:0] mrdata;
   logic        mack;
   modport dev  (input rsel, rwe, raddr, rwdata, bgnt, mrdata, mack,
                 output rrdata, rack, irq, vector, breq, mreq, mwe, maddr, mwdata);
   modport host (output rsel, rwe, raddr, rwdata, bgnt, mrdata, mack,
                 input rrdata, rack, irq, vector, breq, mreq, mwe, maddr, mwdata);
endinterface

// ==== vdc_host.sv ====
// Host end: APB slave, device register access, system memory and arbiter
`timescale 1ns/100ps
module vdc_host (
   input  wire logic        core_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        ce_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             irq_o,
   vdc_if.host              bus
);
   logic [15:0] mem_r [vdc_pkg::MEM_WORDS];
   logic        acc, in_dev, in_mem, ack_r, rsel_r, dev_done_r, mack_r, irq_d_r, breq_d_r;
   logic        err_r, wr_now;
   logic [15:0] mrd_r;
   logic [1:0]  stat_r, en_r;
   logic [31:0] prdata_r;
   logic [7:0]  mem_idx;

   assign acc = psel_i & penable_i;
   assign in_dev = paddr_i[11:5] == vdc_pkg::H_DEVREG[11:5];
   assign in_mem = paddr_i[11] == vdc_pkg::H_MEM[11];
   assign mem_idx = paddr_i[9:2];
   // Memory belongs to the controller while granted; APB waits
   assign bus.bgnt = bus.breq;
   assign bus.mack = mack_r;
   assign bus.mrdata = mrd_r;
   assign bus.rsel = rsel_r;
   assign bus.rwe = pwrite_i;
   assign bus.raddr = paddr_i[4:2];
   assign bus.rwdata = pwdata_i[7:0];
   assign pready_o = in_dev ? dev_done_r : ack_r;
   assign pslverr_o = pready_o & err_r;
   assign prdata_o = prdata_r;
   assign irq_o = |(stat_r & en_r);
   assign wr_now = acc & ack_r & pwrite_i;

   // Device register access, held until the device answers
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         rsel_r <= 1'b0;
         dev_done_r <= 1'b0;
      end else if (ce_i) begin
         dev_done_r <= 1'b0;
         if (acc && in_dev && !rsel_r && !dev_done_r
             && paddr_i[4:2] <= vdc_pkg::REG_LAST) begin
            rsel_r <= 1'b1;
         end
         if (rsel_r && bus.rack) begin
            rsel_r <= 1'b0;
            dev_done_r <= 1'b1;
         end
         if (acc && in_dev && paddr_i[4:2] > vdc_pkg::REG_LAST && !dev_done_r) begin
            dev_done_r <= 1'b1;
         end
      end
   end

   // Local APB answer: one wait state, memory waits out the tenure
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         ack_r <= 1'b0;
         err_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else if (ce_i) begin
         ack_r <= acc && !in_dev && !ack_r && !(in_mem && bus.breq);
         err_r <= in_dev ? paddr_i[4:2] > vdc_pkg::REG_LAST
                 : !(in_mem || paddr_i == vdc_pkg::H_IRQ_STAT
                     || paddr_i == vdc_pkg::H_IRQ_CLR || paddr_i == vdc_pkg::H_IRQ_EN);
         // Device byte loaded as it arrives, so it stands while pready is high
         if (rsel_r && bus.rack) begin
            prdata_r <= {24'h000000, bus.rrdata};
         end else if (in_mem) begin
            prdata_r <= {16'h0000, mem_r[mem_idx]};
         end else if (paddr_i == vdc_pkg::H_IRQ_STAT) begin
            prdata_r <= {16'h0000, bus.vector, 6'h00, stat_r};
         end else if (paddr_i == vdc_pkg::H_IRQ_EN) begin
            prdata_r <= {30'h00000000, en_r};
         end else begin
            prdata_r <= 32'h00000000;
         end
      end
   end

   // System memory: device accesses and APB window
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         mack_r <= 1'b0;
         mrd_r <= 16'h0000;
      end else if (ce_i) begin
         mack_r <= bus.mreq & ~mack_r;
         if (bus.mreq && !mack_r) begin
            mrd_r <= mem_r[bus.maddr[8:1]];
         end
      end
   end

   // Memory array has no reset; contents are set up by software
   always_ff @(posedge core_clk_i) begin
      if (ce_i) begin
         if (reset_n_i && bus.mreq && !mack_r && bus.mwe) begin
            mem_r[bus.maddr[8:1]] <= bus.mwdata;
         end else if (reset_n_i && wr_now && in_mem) begin
            mem_r[mem_idx] <= pwdata_i[15:0];
         end
      end
   end

   // Sticky events, write-one clear loses to a new event
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         stat_r <= 2'b00;
         en_r <= 2'b00;
         irq_d_r <= 1'b0;
         breq_d_r <= 1'b0;
      end else if (ce_i) begin
         irq_d_r <= bus.irq;
         breq_d_r <= bus.breq;
         if (wr_now && paddr_i == vdc_pkg::H_IRQ_EN) begin
            en_r <= pwdata_i[1:0];
         end
         stat_r <= (stat_r & ~((wr_now && paddr_i == vdc_pkg::H_IRQ_CLR) ? pwdata_i[1:0]
                                                                          : 2'b00))
                   | {breq_d_r & ~bus.breq, bus.irq & ~irq_d_r};
      end
   end
endmodule

// ==== vdc_link_sva.sv ====
// Protocol checks on the link between host end and controller end
`timescale 1ns/100ps
module vdc_link_sva #(
   parameter int TEN = 20
) (
   input wire logic        core_clk_i,
   input wire logic        reset_n_i,
   input wire logic        rsel,
   input wire logic        rack,
   input wire logic        breq,
   input wire logic        bgnt,
   input wire logic        mreq,
   input wire logic        mwe,
   input wire logic [23:0] maddr,
   input wire logic        mack
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   logic [15:0] ten_r;
   // Tenure length; cleared whenever the bus is let go
   always_ff @(posedge core_clk_i) begin
      ten_r <= (breq && reset_n_i) ? ten_r + 16'h0001 : 16'h0000;
   end
   property p_mreq_gnt; mreq |-> breq && bgnt; endproperty
   a_mreq_gnt: assert property (p_mreq_gnt) else $error("request outside tenure");
   property p_gnt; bgnt == breq; endproperty
   a_gnt: assert property (p_gnt) else $error("grant differs from request");
   property p_hold; mreq && !mack |=> mreq && $stable(maddr) && $stable(mwe); endproperty
   a_hold: assert property (p_hold) else $error("request changed before answer");
   property p_mack_idle; mack |=> !mack && !mreq; endproperty
   a_mack_idle: assert property (p_mack_idle) else $error("no idle after answer");
   property p_mack_cause; $rose(mack) |-> $past(mreq); endproperty
   a_mack_cause: assert property (p_mack_cause) else $error("answer without request");
   property p_align; mreq |-> !maddr[0]; endproperty
   a_align: assert property (p_align) else $error("odd word address");
   property p_rack_resp; rsel && !rack |=> rack; endproperty
   a_rack_resp: assert property (p_rack_resp) else $error("register answer late");
   property p_rack_pulse; rack |=> !rack; endproperty
   a_rack_pulse: assert property (p_rack_pulse) else $error("register answer stuck");
   property p_tenure; ten_r <= TEN + 2; endproperty
   a_tenure: assert property (p_tenure) else $error("tenure too long");
endmodule

// ==== disk_ctrl_host_dma_interface_test.sv ====
// Bench driving the host end over APB against the controller end
`timescale 1ns/100ps
module disk_ctrl_host_dma_interface_test;
   logic        core_clk_i = 1'b0;
   logic        reset_n_i  = 1'b0;
   logic [11:0] paddr_i    = 12'h000;
   logic        psel_i     = 1'b0;
   logic        penable_i  = 1'b0;
   logic        pwrite_i   = 1'b0;
   logic [31:0] pwdata_i   = 32'h00000000;
   logic [31:0] prdata_o;
   logic        pready_o;
   logic        pslverr_o;
   logic        irq_o;
   logic [1:0]  drive_sel_o;
   logic [3:0]  head_o;
   logic [9:0]  cyl_o;
   logic [31:0] rd;
   logic        err;
   logic        ce         = 1'b1;
   logic [3:0]  drv_rdy    = 4'hF;
   logic        rx_rdy;
   logic        tx_vld;
   logic [15:0] tx_data;
   int          n_mismatch = 0;
   int          compares   = 0;
   vdc_if vdc_if_i ();
   vdc_host vdc_host_i (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ce_i(ce),
      .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .irq_o(irq_o), .bus(vdc_if_i));
   // Disk side kept steady so buffer contents are predictable
   vdc_dev #(.TENURE_CYCLES(20)) vdc_dev_i (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
      .ce_i(ce), .bus(vdc_if_i), .drive_ready_i(drv_rdy), .dsk_rx_data_i(16'hA5C3),
      .dsk_rx_valid_i(1'b1), .dsk_rx_ready_o(rx_rdy), .dsk_tx_data_o(tx_data),
      .dsk_tx_valid_o(tx_vld), .dsk_tx_ready_i(1'b1), .drive_sel_o(drive_sel_o),
      .head_o(head_o), .cyl_o(cyl_o));
   vdc_link_sva #(.TEN(20)) vdc_link_sva_i (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
      .rsel(vdc_if_i.rsel), .rack(vdc_if_i.rack), .breq(vdc_if_i.breq),
      .bgnt(vdc_if_i.bgnt), .mreq(vdc_if_i.mreq), .mwe(vdc_if_i.mwe),
      .maddr(vdc_if_i.maddr), .mack(vdc_if_i.mack));
   always #5 core_clk_i = ~core_clk_i;
   function automatic logic [11:0] mw(input int i);
      return vdc_pkg::H_MEM + 12'(4 * i);
   endfunction
   function automatic logic [11:0] dr(input int i);
      return vdc_pkg::H_DEVREG + 12'(4 * i);
   endfunction
   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", w, e, g);
      end
   endtask
   // One APB transfer; waits on pready as long as it takes, the watchdog ends a hang
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel_i <= 1'b1;
      paddr_i <= a;
      pwrite_i <= wr;
      pwdata_i <= d;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge core_clk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task automatic rdc(input string w, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h00000000);
      chk(w, e, rd);
   endtask
   // One command: c=0 four-word read, c=1 block read with ECC, c=2 unknown op,
   // c=3 drive not ready, c=4 four-word write from memory to disk
   task automatic run(input int c);
      logic [15:0] ecb [5];
      ecb = '{{8'h03, 2'h0, 1'(c), 1'(c), (c == 2) ? 4'h9 : (c == 4) ? 4'h3 : 4'h2}, 16'h0005,
              16'h0000, 16'h0040, 16'h0004};
      drv_rdy <= (c == 3) ? 4'hE : 4'hF;
      for (int i = 0; i < 5; i++) apb(1'b1, mw(8 + i), {16'h0000, ecb[i]});
      for (int i = 0; i < 4; i++) apb(1'b1, mw(32 + i), (c == 4) ? 32'h1234 : 32'h0);
      apb(1'b1, mw(13), 32'h00000000);
      apb(1'b1, dr(2), 32'h00000010);
      apb(1'b1, dr(3), 32'h00000000);
      apb(1'b1, dr(4), 32'h00000000);
      apb(1'b1, dr(0), 32'h00000001);
      for (int n = 0; n < 3000 && irq_o !== 1'b1; n++) @(posedge core_clk_i);
      chk("irq", 32'h1, {31'h0, irq_o});
      rdc("status", mw(13), (c == 2) ? 32'h3 : (c == 3) ? 32'h5 : 32'h1);
      for (int i = 0; i < 5; i++) rdc("static", mw(8 + i), {16'h0000, ecb[i]});
      for (int i = 0; i < 4; i++) begin
         rdc("buf", mw(32 + i), (c == 4) ? 32'h1234 : (c > 1) ? 32'h0 : 32'hA5C3);
      end
      if (c < 2 || c == 4) begin
         rdc("resid", mw(14), 32'h0);
         chk("pos", 32'h00000C05, {18'h0, drive_sel_o, head_o, cyl_o});
         chk("tx", (c == 4) ? 32'h1234 : 32'h0, {14'h0, rx_rdy, tx_vld, tx_data});
         rdc("src", dr(5), 32'h1);
      end else begin
         if (c == 3) rdc("drv stat", dr(6), 32'h0000000E);
         apb(1'b0, dr(5), 32'h00000000);
         chk("src err", 32'h1, {31'h0, rd[1]});
      end
      apb(1'b1, vdc_pkg::H_IRQ_CLR, 32'h00000001);
      chk("irq clr", 32'h0, {31'h0, irq_o});
   endtask
   task automatic finish_test();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Main sequence: reset values, refused index, frozen enable write, then five commands
   initial begin
      repeat (6) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      @(posedge core_clk_i);
      rdc("vector", dr(1), 32'h0000000F);
      rdc("ctrl", dr(0), 32'h00000000);
      apb(1'b0, dr(7), 32'h00000000);
      chk("idx7", 32'h1, {31'h0, err});
      // Clock enable low: the host must not answer until it is raised again
      ce <= 1'b0;
      fork
         apb(1'b1, vdc_pkg::H_IRQ_EN, 32'h00000001);
         begin
            repeat (3) @(posedge core_clk_i);
            chk("frozen", 32'h0, {31'h0, pready_o});
            ce <= 1'b1;
         end
      join
      for (int c = 0; c < 5; c++) run(c);
      finish_test();
   end
   // Watchdog well past the expected run length
   initial begin
      #900000;
      n_mismatch++;
      finish_test();
   end
endmodule
